// ===== common/pcfd_regs.vh
// Constants for the clock fan-out divider: register map, fields, resets and timing
`ifndef PCFD_REGS_VH
`define PCFD_REGS_VH

// Register byte addresses
`define PCFD_AW 8
`define PCFD_ADDR_CTRL 8'h00
`define PCFD_ADDR_STAB 8'h04
`define PCFD_ADDR_STATUS 8'h08
`define PCFD_ADDR_PROGRESS 8'h0C

// Control register fields (write-only actions)
`define PCFD_CTRL_RELOCK 0
`define PCFD_CTRL_SLIP_CLR 1

// Status register fields
`define PCFD_ST_LOCKED 0
`define PCFD_ST_SEL 1
`define PCFD_ST_BYPASS 2
`define PCFD_ST_OE_N 3
`define PCFD_ST_SLIP 4
`define PCFD_ST_ACQ 5

// Stabilization count width and default, in reference cycles
`define PCFD_STAB_W 16
`define PCFD_STAB_DEFAULT 16'h0400

// Oscillator span limits in MHz, and the model's oscillator (the system clock)
`define PCFD_OSC_MIN_MHZ 100
`define PCFD_OSC_MAX_MHZ 200
`define PCFD_SYS_CLK_MHZ 100

// Divider ratios: half and quarter of the oscillator
`define PCFD_DIV_HALF 2
`define PCFD_DIV_QUARTER 4

// Expected feedback edges per reference period when in frequency lock
`define PCFD_FB_PER_REF 2'h1

// Bank width
`define PCFD_BANK_W 3

// Sampled input vector positions for the edge detectors
`define PCFD_IN_REF 0
`define PCFD_IN_FB 1
`define PCFD_IN_CLR 2
`define PCFD_IN_SEL 3
`define PCFD_IN_BYP 4
`define PCFD_IN_OEN 5
`define PCFD_IN_N 6

// Idle levels of the sampled pins: enable and clear rest high
`define PCFD_PIN_IDLE 6'h24

`endif

// ===== testbench/pcfd_board.sv
// Board side: reference source and the single feedback wire
`timescale 1ns/1ps
module pcfd_board (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Output chosen for feedback
	input wire fed_out,
	input wire fed_oe,
	// Pins into the device
	output reg reference_clock_in,
	output wire loop_feedback_in
);
	reg idle_r;
	// Reference at half the oscillator rate keeps the loop in its input range
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reference_clock_in <= 1'b0;
			idle_r <= 1'b0;
		end else begin
			reference_clock_in <= ~reference_clock_in;
			idle_r <= ~idle_r;
		end
	end
	// Exactly one output wired back; a released line shows a moving pattern, never the old level
	assign loop_feedback_in = fed_oe ? fed_out : idle_r;
endmodule // pcfd_board

// ===== testbench/pcfd_props.sv
// Port checker for the clock fan-out divider
`timescale 1ns/1ps
module pcfd_props #(
	parameter BANK_W = 3
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Pins
	input wire reference_clock_in,
	input wire half_rate_clear,
	input wire bank_ratio_select,
	input wire loop_bypass,
	input wire output_enable_n,
	// Outputs
	input wire [BANK_W-1:0] first_bank_outputs,
	input wire [BANK_W-1:0] first_bank_outputs_oe,
	input wire [BANK_W-1:0] second_bank_outputs,
	input wire [BANK_W-1:0] second_bank_outputs_oe,
	input wire loop_locked
);
	reg [2:0] calm_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Cycles free of bypass and clear; waits out reset and divider restarts before judging rates
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			calm_r <= 3'h0;
		else if (loop_bypass || half_rate_clear)
			calm_r <= 3'h0;
		else if (calm_r != 3'h5)
			calm_r <= calm_r + 3'h1;
	end
	property p_oe_follow;
		first_bank_outputs_oe == {BANK_W{!output_enable_n}} && second_bank_outputs_oe == {BANK_W{!output_enable_n}};
	endproperty
	property p_bank_same;
		first_bank_outputs == {BANK_W{first_bank_outputs[0]}} && second_bank_outputs == {BANK_W{second_bank_outputs[0]}};
	endproperty
	property p_half_toggle;
		calm_r == 3'h5 |-> second_bank_outputs != $past(second_bank_outputs);
	endproperty
	property p_quarter;
		(bank_ratio_select [*5]) ##0 (calm_r == 3'h5) |-> first_bank_outputs != $past(first_bank_outputs, 2);
	endproperty
	property p_same_rate;
		(!bank_ratio_select [*5]) ##0 (calm_r == 3'h5) |-> first_bank_outputs == second_bank_outputs;
	endproperty
	property p_bypass_copy;
		(loop_bypass [*3]) |-> second_bank_outputs == {BANK_W{$past(reference_clock_in)}};
	endproperty
	property p_clear;
		(!loop_bypass && half_rate_clear ##1 !half_rate_clear) |-> ##[0:2] (first_bank_outputs == {BANK_W{1'b0}}
			&& second_bank_outputs == {BANK_W{1'b0}});
	endproperty
	property p_lock_drop;
		loop_locked && (loop_bypass || output_enable_n) |-> ##[1:2] !loop_locked;
	endproperty
	property p_sel_drop;
		loop_locked && (bank_ratio_select != $past(bank_ratio_select)) |-> ##[1:2] !loop_locked;
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("enable mismatch");
	a_bank_same: assert property (p_bank_same) else $error("bank bits differ");
	a_half_toggle: assert property (p_half_toggle) else $error("half rate stalled");
	a_quarter: assert property (p_quarter) else $error("quarter rate wrong");
	a_same_rate: assert property (p_same_rate) else $error("banks differ at select low");
	a_bypass_copy: assert property (p_bypass_copy) else $error("bypass not copying");
	a_clear: assert property (p_clear) else $error("clear ignored");
	a_lock_drop: assert property (p_lock_drop) else $error("lock held");
	a_sel_drop: assert property (p_sel_drop) else $error("lock held over select");
	c_lock: cover property ($rose(loop_locked));
	c_clear: cover property ($fell(half_rate_clear));
	c_bypass: cover property (loop_bypass [*3]);
endmodule // pcfd_props

bind pcfd_top pcfd_props #(.BANK_W(BANK_W)) i_props (.ref_clk(ref_clk), .rst(rst),
	.reference_clock_in(reference_clock_in), .half_rate_clear(half_rate_clear),
	.bank_ratio_select(bank_ratio_select), .loop_bypass(loop_bypass), .output_enable_n(output_enable_n),
	.first_bank_outputs(first_bank_outputs), .first_bank_outputs_oe(first_bank_outputs_oe),
	.second_bank_outputs(second_bank_outputs), .second_bank_outputs_oe(second_bank_outputs_oe),
	.loop_locked(loop_locked));

// ===== testbench/testbench.sv
// Self-checking bench for the clock fan-out divider
`timescale 1ns/1ps
`include "pcfd_regs.vh"
module testbench;
	reg ref_clk, rst, clr, sel, byp, oe_n, reg_wr, reg_rd, r;
	reg [7:0] reg_addr;
	reg [31:0] reg_wdata;
	reg [2:0] prev, q0, q1;
	wire ref_in, fb_in, locked;
	wire [2:0] y1, y1_oe, y2, y2_oe;
	wire [31:0] reg_rdata;
	integer error_cnt, cmp_count, i;
	integer cyc = 0;
	// Small stabilization count keeps the lock waits short
	pcfd_top #(.STAB_REF_CYCLES(16'h0004)) i_dut (.ref_clk(ref_clk), .rst(rst), .reference_clock_in(ref_in),
		.loop_feedback_in(fb_in), .half_rate_clear(clr), .bank_ratio_select(sel), .loop_bypass(byp),
		.output_enable_n(oe_n), .first_bank_outputs(y1), .first_bank_outputs_oe(y1_oe),
		.second_bank_outputs(y2), .second_bank_outputs_oe(y2_oe), .loop_locked(locked),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	pcfd_board i_board (.ref_clk(ref_clk), .rst(rst), .fed_out(y2[0]), .fed_oe(y2_oe[0]),
		.reference_clock_in(ref_in), .loop_feedback_in(fb_in));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("BAD %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge ref_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
		end
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input [7:0] a, input [31:0] exp, input string what);
		begin
			@(posedge ref_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			#1 chk(what, exp, reg_rdata);
		end
	endtask
	task wait_lock;
		begin
			// Let a restart requested just before the call take effect first
			repeat (2) @(posedge ref_clk);
			i = 0;
			while (locked !== 1'b1 && i < 300) begin
				@(posedge ref_clk);
				i = i + 1;
			end
			#1 chk("locked", 32'h1, {31'h0, locked});
		end
	endtask
	task final_report;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
			if (error_cnt == 0 && cmp_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			$display("BAD timeout");
			final_report;
		end
	end
	initial begin
		error_cnt = 0;
		cmp_count = 0;
		rst = 1'b1;
		{clr, sel, byp, oe_n, reg_wr, reg_rd} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		wr(`PCFD_ADDR_STAB, 32'hABCD0003);
		rd(`PCFD_ADDR_STAB, 32'h3, "stab");
		rd(8'h10, 32'h0, "unmapped");
		$display("register test done");
		repeat (4) @(posedge ref_clk);
		#1 prev = y2;
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge ref_clk);
			#1 chk("half", {29'h0, ~prev}, {29'h0, y2});
			chk("same rate", {29'h0, y2}, {29'h0, y1});
			prev = y2;
		end
		@(posedge ref_clk);
		sel <= 1'b1;
		repeat (6) @(posedge ref_clk);
		#1 q0 = y1;
		@(posedge ref_clk);
		#1 q1 = y1;
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge ref_clk);
			#1 chk("quarter", {29'h0, ~q0}, {29'h0, y1});
			q0 = q1;
			q1 = y1;
		end
		$display("divider test done");
		wr(`PCFD_ADDR_CTRL, 32'h2);
		@(posedge ref_clk);
		sel <= 1'b0;
		wait_lock;
		rd(`PCFD_ADDR_STATUS, 32'h1, "status");
		rd(`PCFD_ADDR_PROGRESS, 32'h3, "progress");
		@(posedge ref_clk);
		sel <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("select unlock", 32'h0, {31'h0, locked});
		wait_lock;
		wr(`PCFD_ADDR_CTRL, 32'h1);
		#1 chk("relock", 32'h0, {31'h0, locked});
		rd(`PCFD_ADDR_STATUS, 32'h22, "acquiring");
		wait_lock;
		@(posedge ref_clk);
		oe_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("outputs off", 32'h0, {26'h0, y1_oe, y2_oe});
		chk("enable unlock", 32'h0, {31'h0, locked});
		@(posedge ref_clk);
		oe_n <= 1'b0;
		#1 chk("outputs on", 32'h3F, {26'h0, y1_oe, y2_oe});
		$display("lock test done");
		@(posedge ref_clk);
		clr <= 1'b1;
		repeat (2) @(posedge ref_clk);
		clr <= 1'b0;
		r = 1'b0;
		repeat (3) begin
			@(posedge ref_clk);
			#1 if (y1 === 3'h0 && y2 === 3'h0)
				r = 1'b1;
		end
		chk("clear", 32'h1, {31'h0, r});
		@(posedge ref_clk);
		byp <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 r = ref_in;
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge ref_clk);
			#1 chk("bypass", {29'h0, {3{r}}}, {29'h0, y2});
			chk("bypass first", {29'h0, {3{r}}}, {29'h0, y1});
			r = ref_in;
		end
		@(posedge ref_clk);
		byp <= 1'b0;
		$display("clear and bypass test done");
		final_report;
	end
endmodule // testbench

// ===== verilog/pcfd_edge.v
// Edge detector for one synchronous input: held level plus rise and fall pulses
`timescale 1ns/1ps
module pcfd_edge (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Sampled input and its reset level
	input wire din,
	input wire rst_level,
	// Edge results
	output wire level,
	output wire rise,
	output wire fall
);

reg prev_r;
reg armed_r;

// Last level; arms only after reset so the reset constant never fakes an edge
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		prev_r <= 1'b0;
		armed_r <= 1'b0;
	end else begin
		prev_r <= din;
		armed_r <= 1'b1;
	end
end

// Pulses are combinational so the caller loses no cycle on a divider edge
assign level = armed_r ? prev_r : rst_level;
assign rise = armed_r & din & ~prev_r;
assign fall = armed_r & ~din & prev_r;

endmodule // pcfd_edge

// ===== verilog/pcfd_top.v
// Clock fan-out divider: half and quarter rate banks, bypass, clear, lock tracking
// Operation
// - Make half and quarter clocks, 50% duty.
// - Select level picks clock for first bank.
// - Oscillator spans 100 to 200 MHz.
// - Half-rate feedback: outputs at reference or half.
// - Quarter-rate feedback: outputs at reference or double.
// - Config A: select high, first bank half.
// - Config B: select high, second bank double.
// - Enable high tri-states all outputs.
// - Bypass routes reference around loop.
// - Stabilization after power, select, bypass, enable.
// - Outputs keep 50% duty regardless of reference; in bypass the outputs follow the reference duty.
// - One reference fans to two banks of three.
// - Falling clear edge resets half-rate dividers.
// - First bank half/quarter; second bank always half.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pcfd_regs.vh"
module pcfd_top #(
	parameter BANK_W = `PCFD_BANK_W,
	parameter STAB_W = `PCFD_STAB_W,
	parameter [`PCFD_STAB_W-1:0] STAB_REF_CYCLES = `PCFD_STAB_DEFAULT
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Device pins, sampled on ref_clk
	input wire reference_clock_in,
	input wire loop_feedback_in,
	input wire half_rate_clear,
	input wire bank_ratio_select,
	input wire loop_bypass,
	input wire output_enable_n,
	// First bank outputs
	output wire [BANK_W-1:0] first_bank_outputs,
	output wire [BANK_W-1:0] first_bank_outputs_oe,
	// Second bank outputs
	output wire [BANK_W-1:0] second_bank_outputs,
	output wire [BANK_W-1:0] second_bank_outputs_oe,
	// Lock indication
	output wire loop_locked,
	// Register port
	input wire [`PCFD_AW-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [31:0] reg_rdata
);

// Lock tracking states
localparam [2:0] ST_HOLD = 3'h1;
localparam [2:0] ST_ACQ = 3'h2;
localparam [2:0] ST_LOCK = 3'h4;

// Oscillator span must fit the model clock; the loop only exists inside it
localparam OSC_IN_SPAN = (`PCFD_SYS_CLK_MHZ >= `PCFD_OSC_MIN_MHZ) &&
	(`PCFD_SYS_CLK_MHZ <= `PCFD_OSC_MAX_MHZ);
localparam integer QUARTER_STEPS = `PCFD_DIV_QUARTER / `PCFD_DIV_HALF - 1;
localparam [1:0] QUARTER_LAST = QUARTER_STEPS[1:0];

// Address decode shared by the write and read paths
function hit;
	input [`PCFD_AW-1:0] addr;
	input [`PCFD_AW-1:0] target;
	begin
		hit = (addr == target);
	end
endfunction

// Edge detectors for every sampled pin
wire [`PCFD_IN_N-1:0] pin_in;
wire [`PCFD_IN_N-1:0] pin_rst_level;
wire [`PCFD_IN_N-1:0] pin_level;
wire [`PCFD_IN_N-1:0] pin_rise;
wire [`PCFD_IN_N-1:0] pin_fall;

assign pin_in = {output_enable_n, loop_bypass, bank_ratio_select, half_rate_clear,
	loop_feedback_in, reference_clock_in};
// Enable and clear idle high; others idle low, so reset never looks like an edge
assign pin_rst_level = `PCFD_PIN_IDLE;

genvar gi;
generate
	for (gi = 0; gi < `PCFD_IN_N; gi = gi + 1) begin : g_edge
		pcfd_edge u_edge (
			.ref_clk(ref_clk),
			.rst(rst),
			.din(pin_in[gi]),
			.rst_level(pin_rst_level[gi]),
			.level(pin_level[gi]),
			.rise(pin_rise[gi]),
			.fall(pin_fall[gi])
		);
	end
endgenerate

// Named edges used by the dividers and the lock logic
wire ref_rise = pin_rise[`PCFD_IN_REF];
wire fb_rise = pin_rise[`PCFD_IN_FB];
wire clr_fall = pin_fall[`PCFD_IN_CLR];
wire sel_change = pin_rise[`PCFD_IN_SEL] | pin_fall[`PCFD_IN_SEL];
wire byp_enable_loop = pin_fall[`PCFD_IN_BYP];
wire oe_enable = pin_fall[`PCFD_IN_OEN];

// Dividers: oscillator is the system clock, half toggles each cycle, quarter every two
reg half_r;
reg quarter_r;
reg [1:0] quarter_cnt_r;
reg half_nxt;
reg quarter_nxt;
reg [1:0] quarter_cnt_nxt;

always @* begin
	half_nxt = ~half_r;
	quarter_cnt_nxt = (quarter_cnt_r == QUARTER_LAST) ? 2'h0 : quarter_cnt_r + 2'h1;
	quarter_nxt = (quarter_cnt_r == QUARTER_LAST) ? ~quarter_r : quarter_r;
	// Both dividers restart together so the banks stay phase aligned after a clear
	if (clr_fall) begin
		half_nxt = 1'b0;
		quarter_nxt = 1'b0;
		quarter_cnt_nxt = 2'h0;
	end
end

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		half_r <= 1'b0;
		quarter_r <= 1'b0;
		quarter_cnt_r <= 2'h0;
	end else begin
		half_r <= half_nxt;
		quarter_r <= quarter_nxt;
		quarter_cnt_r <= quarter_cnt_nxt;
	end
end

// Bank data: decoded from the select level straight off the divider next values
reg [BANK_W-1:0] first_r;
reg [BANK_W-1:0] second_r;
reg first_bit_nxt;
reg second_bit_nxt;

always @* begin
	if (pin_in[`PCFD_IN_BYP]) begin
		// Test path skips the dividers; duty follows the reference here
		first_bit_nxt = reference_clock_in;
		second_bit_nxt = reference_clock_in;
	end else begin
		// Select high gives the quarter clock; config A or B follows from what is fed back
		first_bit_nxt = bank_ratio_select ? quarter_nxt : half_nxt;
		second_bit_nxt = half_nxt;
	end
end

// One source per bank fans to every bit of that bank, so all three track with no skew
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		first_r <= {BANK_W{1'b0}};
		second_r <= {BANK_W{1'b0}};
	end else begin
		first_r <= {BANK_W{first_bit_nxt}};
		second_r <= {BANK_W{second_bit_nxt}};
	end
end

assign first_bank_outputs = first_r;
assign second_bank_outputs = second_r;
// Enable is active low and acts at once on every output; each pin has its own enable
genvar bi;
generate
	for (bi = 0; bi < BANK_W; bi = bi + 1) begin : g_oe
		assign first_bank_outputs_oe[bi] = ~output_enable_n;
		assign second_bank_outputs_oe[bi] = ~output_enable_n;
	end
endgenerate

// Register write strobes
wire wr_ctrl = reg_wr & hit(reg_addr, `PCFD_ADDR_CTRL);
wire wr_stab = reg_wr & hit(reg_addr, `PCFD_ADDR_STAB);
wire relock_req = wr_ctrl & reg_wdata[`PCFD_CTRL_RELOCK];
wire slip_clr = wr_ctrl & reg_wdata[`PCFD_CTRL_SLIP_CLR];

// Stabilization length, steered by software
reg [STAB_W-1:0] stab_r;

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		stab_r <= STAB_REF_CYCLES;
	end else if (wr_stab) begin
		stab_r <= reg_wdata[STAB_W-1:0];
	end
end

// Lock state, declared here because the feedback check reads it
reg [2:0] state_r;
reg [2:0] state_nxt;

// Feedback check: the board's loop wire must give one feedback edge per reference period
// The count saturates at three so a runaway feedback still reads as a slip
reg [1:0] fb_cnt_r;
reg [1:0] fb_cnt_nxt;
reg [1:0] fb_seen;
reg seen_ref_r;
reg slip_evt;

always @* begin
	fb_seen = (fb_cnt_r == 2'h3) ? fb_cnt_r : fb_cnt_r + {1'b0, fb_rise};
	fb_cnt_nxt = ref_rise ? 2'h0 : fb_seen;
	slip_evt = ref_rise & seen_ref_r & (fb_seen != `PCFD_FB_PER_REF);
end

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		fb_cnt_r <= 2'h0;
		seen_ref_r <= 1'b0;
	end else begin
		fb_cnt_r <= fb_cnt_nxt;
		// Ignore the partial first window after the loop is (re)opened
		if (state_r == ST_HOLD) begin
			seen_ref_r <= 1'b0;
		end else if (ref_rise) begin
			seen_ref_r <= 1'b1;
		end
	end
end

// Events that disturb the reference or feedback path and restart the count
wire restart_pin = sel_change | byp_enable_loop | oe_enable;
// Software relock and a detected slip restart it as well
wire restart_sw = relock_req | slip_evt;
wire restart = restart_pin | restart_sw;
// Loop held open while bypassed or while outputs float (feedback broken)
// Limitation: the span test is static, so a model clock outside it never locks
wire loop_open = pin_in[`PCFD_IN_BYP] | output_enable_n | ~OSC_IN_SPAN;

// Lock state machine with reference-cycle counter
reg [STAB_W-1:0] count_r;
reg [STAB_W-1:0] count_nxt;

always @* begin
	state_nxt = state_r;
	count_nxt = count_r;
	case (state_r)
		ST_HOLD: begin
			// Loop open: count parked at zero until feedback can exist
			count_nxt = {STAB_W{1'b0}};
			if (!loop_open) begin
				state_nxt = ST_ACQ;
			end
		end
		ST_ACQ: begin
			// Count reference edges; any disturbance starts over
			if (loop_open) begin
				state_nxt = ST_HOLD;
				count_nxt = {STAB_W{1'b0}};
			end else if (restart) begin
				count_nxt = {STAB_W{1'b0}};
			end else if (count_r >= stab_r) begin
				state_nxt = ST_LOCK;
			end else if (ref_rise) begin
				count_nxt = count_r + {{(STAB_W-1){1'b0}}, 1'b1};
			end
		end
		ST_LOCK: begin
			// Count frozen at its end value while lock holds
			if (loop_open) begin
				state_nxt = ST_HOLD;
				count_nxt = {STAB_W{1'b0}};
			end else if (restart) begin
				state_nxt = ST_ACQ;
				count_nxt = {STAB_W{1'b0}};
			end
		end
		default: begin
			state_nxt = ST_HOLD;
			count_nxt = {STAB_W{1'b0}};
		end
	endcase
end

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		state_r <= ST_HOLD;
		count_r <= {STAB_W{1'b0}};
	end else begin
		state_r <= state_nxt;
		count_r <= count_nxt;
	end
end

assign loop_locked = (state_r == ST_LOCK);

// Sticky slip flag; a slip in the clearing cycle survives
// Software clears it by writing the control register
reg slip_r;

always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		slip_r <= 1'b0;
	end else if (slip_evt) begin
		slip_r <= 1'b1;
	end else if (slip_clr) begin
		slip_r <= 1'b0;
	end
end

// Status bits show the sampled pin levels, not the raw pins
// Read mux; unmapped addresses read zero
reg [31:0] rdata_r;
reg [31:0] rdata_nxt;

always @* begin
	rdata_nxt = 32'h00000000;
	if (hit(reg_addr, `PCFD_ADDR_STAB)) begin
		rdata_nxt[STAB_W-1:0] = stab_r;
	end else if (hit(reg_addr, `PCFD_ADDR_STATUS)) begin
		rdata_nxt[`PCFD_ST_LOCKED] = loop_locked;
		rdata_nxt[`PCFD_ST_SEL] = pin_level[`PCFD_IN_SEL];
		rdata_nxt[`PCFD_ST_BYPASS] = pin_level[`PCFD_IN_BYP];
		rdata_nxt[`PCFD_ST_OE_N] = pin_level[`PCFD_IN_OEN];
		rdata_nxt[`PCFD_ST_SLIP] = slip_r;
		rdata_nxt[`PCFD_ST_ACQ] = (state_r == ST_ACQ);
	end else if (hit(reg_addr, `PCFD_ADDR_PROGRESS)) begin
		rdata_nxt[STAB_W-1:0] = count_r;
	end
end

// Read data stand for exactly the cycle after the strobe
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		rdata_r <= 32'h00000000;
	end else if (reg_rd) begin
		rdata_r <= rdata_nxt;
	end else begin
		rdata_r <= 32'h00000000;
	end
end

// Read data leave from a flop so the bus sees one clean cycle
assign reg_rdata = rdata_r;

endmodule // pcfd_top
